/* File: design/acpi_seq_params.svh */
`ifndef ACPI_SEQ_PARAMS_SVH
`define ACPI_SEQ_PARAMS_SVH

// ==========================================================================
// Clock rate
`define ACPI_CLK_HZ          20000000
`define ACPI_CLK_PER_US      (`ACPI_CLK_HZ / 1000000)

// ==========================================================================
// Times in microseconds
`define ACPI_POR_EXT_US      3300
`define ACPI_DEGLITCH_US     200
`define ACPI_MAIN_SETTLE_US  50000
`define ACPI_FAULT_DELAY_US  10

// ==========================================================================
// Derived cycle counts (all figures divide evenly at 20 MHz)
`define ACPI_POR_EXT_CYC     (`ACPI_POR_EXT_US * `ACPI_CLK_PER_US)
`define ACPI_DEGLITCH_CYC    (`ACPI_DEGLITCH_US * `ACPI_CLK_PER_US)
`define ACPI_MAIN_SETTLE_CYC (`ACPI_MAIN_SETTLE_US * `ACPI_CLK_PER_US)
`define ACPI_FAULT_DELAY_CYC (`ACPI_FAULT_DELAY_US * `ACPI_CLK_PER_US)

// ==========================================================================
// Pin levels and reset values
`define ACPI_MEMSEL_3V3      1'b1
`define ACPI_FAULT_ACTIVE    1'b1
`define ACPI_FAULT_FORCED    1'b0

`endif

/* File: design/acpi_seq_pkg.sv */
package acpi_seq_pkg;

  // Decoded system power state
  typedef enum logic [1:0] {
    ST_ACTIVE,
    ST_S3,
    ST_S45
  } power_state_t;

  // Memory active-state pass device mode
  typedef enum logic [1:0] {
    MEM_DRIVE_OFF,
    MEM_DRIVE_REGULATE,
    MEM_DRIVE_FULL
  } mem_drive_t;

endpackage

/* File: design/rail_cmd_if.sv */
`timescale 1ns/1ps
`default_nettype none

// Rail command bundle from the decoder to the output stage
interface rail_cmd_if;
  logic                     dual3v3On;
  logic                     dual5vOn;
  logic                     memOn;
  logic                     activeSwitch;
  logic                     standby5v;
  logic                     standby3v3Reg;
  logic                     memSleepPass;
  acpi_seq_pkg::mem_drive_t memDrive;

  modport source (
    output dual3v3On,
    output dual5vOn,
    output memOn,
    output activeSwitch,
    output standby5v,
    output standby3v3Reg,
    output memSleepPass,
    output memDrive
  );

  modport sink (
    input dual3v3On,
    input dual5vOn,
    input memOn,
    input activeSwitch,
    input standby5v,
    input standby3v3Reg,
    input memSleepPass,
    input memDrive
  );
endinterface

`default_nettype wire

/* File: design/delay_timer.sv */
`timescale 1ns/1ps
`default_nettype none

// Saturating interval counter; expired stays high until restarted
module delay_timer #(
  parameter int unsigned CYCLES = 4
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // Control
  input  wire logic restart,
  // Status
  output logic      expired
);
  localparam int unsigned   W    = $clog2(CYCLES + 1);
  localparam logic [W-1:0]  LAST = W'(CYCLES);

  logic [W-1:0] count;

  // Count up while not restarted, hold at the end
  always_ff @(posedge clk) begin
    if (rst || restart) begin
      count <= '0;
    end else if (count != LAST) begin
      count <= count + W'(1);
    end
  end

  assign expired = (count == LAST) && !restart;
endmodule

`default_nettype wire

/* File: design/rail_decoder.sv */
`timescale 1ns/1ps
`default_nettype none

// Maps state, latched enables and memory level onto rail commands
module rail_decoder (
  // Operating context
  input  wire logic                       railsAllowed,
  input  wire logic                       mainReady,
  input  wire acpi_seq_pkg::power_state_t state,
  // Latched configuration
  input  wire logic                       keep3v3SleepN,
  input  wire logic                       keep5vSleep,
  input  wire logic                       mem3v3,
  // Commands
  rail_cmd_if.source                      cmd
);
  logic isActive;
  logic isSleep;

  assign isActive = (state == acpi_seq_pkg::ST_ACTIVE);
  assign isSleep  = !isActive;

  // Rail targets; everything off while POR or shutdown holds
  always_comb begin
    cmd.dual3v3On = railsAllowed && ((state != acpi_seq_pkg::ST_S45) || !keep3v3SleepN);
    cmd.dual5vOn  = railsAllowed && (isActive || keep5vSleep);
    cmd.memOn     = railsAllowed && (state != acpi_seq_pkg::ST_S45);
  end

  // Switch drives; active paths wait for a settled main supply
  always_comb begin
    cmd.activeSwitch  = railsAllowed && isActive && mainReady;
    cmd.standby5v     = isSleep && cmd.dual5vOn;
    cmd.standby3v3Reg = isSleep && cmd.dual3v3On;
    cmd.memSleepPass  = isSleep && cmd.memOn;
    cmd.memDrive      = acpi_seq_pkg::MEM_DRIVE_OFF;
    if (cmd.memOn && isActive && mainReady) begin
      cmd.memDrive = mem3v3 ? acpi_seq_pkg::MEM_DRIVE_FULL : acpi_seq_pkg::MEM_DRIVE_REGULATE;
    end
  end
endmodule

`default_nettype wire

/* File: design/acpi_sleep_rail_sequencer.sv */
// Contract
// - Hold internal reset until standby supply stays good for 3.3 ms.
// - Begin soft-start after reset release in any state, active or sleep.
// - Capture memory level 2.5V or 3.3V at each reset trip, keep it.
// - 3.3V dual on in active and S3; in S4/S5 follows low-active keep.
// - 5V dual on in active; in sleep on only when 5V keep is set.
// - Memory rail on in active and S3, off in S4/S5.
// - S5 low with S3 high is illegal; rails keep previous state.
// - Only active-to-sleep and sleep-to-active moves are accepted.
// - Keep enables follow only in active, reset or shutdown; frozen in sleep.
// - Sleep input change restarts 200 us deglitch; act at its end if valid.
// - Invalid inputs at deglitch end keep the last valid state.
// - Watch enabled memory, 3.3V dual and 5V dual rails for under-voltage once ramp is done.
// - Active states drive the shared active switch gate.
// - Sleep with 5V dual enabled turns on the standby 5V switch.
// - Active memory drive fully on for 3.3V, regulating for 2.5V.
// - S3 feeds memory through the internal pass path; S4/S5 leaves it off.
// - 12V sense decides whether main supply is present for active use.
// - Power-up into active keeps switches off until 50 ms after 12V good.
// - Soft-start held low shuts all rails and forces fault low.
// - Rail below 69 percent raises fault without shutting anything.
`timescale 1ns/1ps
`default_nettype none

`include "acpi_seq_params.svh"

module acpi_sleep_rail_sequencer #(
  parameter int unsigned POR_CYCLES        = `ACPI_POR_EXT_CYC,
  parameter int unsigned MAIN_READY_CYCLES = `ACPI_MAIN_SETTLE_CYC
) (
  // Clock and reset
  input  wire logic                      clk,
  input  wire logic                      rst,
  // Supply comparators
  input  wire logic                      standbySupplyGood,
  input  wire logic                      main12vGood,
  // Sleep requests and keep enables from the chipset
  input  wire logic                      s3RequestN,
  input  wire logic                      s5RequestN,
  input  wire logic                      keep_3v3_sleep_enable_n,
  input  wire logic                      keep_5v_sleep_enable,
  // Soft-start node status
  input  wire logic                      softStartHeldLow,
  input  wire logic                      softStartRampDone,
  // Under-voltage comparators (high when below 69 percent)
  input  wire logic                      memoryRailUnder,
  input  wire logic                      dual3v3RailUnder,
  input  wire logic                      dual5vRailUnder,
  // Shared fault and memory-select pin
  input  wire logic                      fault_and_memsel_pin_in,
  output logic                           fault_and_memsel_pin_out,
  output logic                           fault_and_memsel_pin_oe,
  // Rail drives
  output logic                           active_switch_drive,
  output logic                           standby_5v_switch_drive,
  output logic                           standby_3v3_regulator_drive,
  output var acpi_seq_pkg::mem_drive_t   memory_active_drive,
  output logic                           memorySleepPass,
  // Status
  output logic                           porAsserted,
  output logic                           softStartEnable,
  output logic                           memLevel3v3,
  output logic                           dual3v3RailOn,
  output logic                           dual5vRailOn,
  output logic                           memoryRailOn,
  output var acpi_seq_pkg::power_state_t powerState
);

  // ========================================================================
  // Internal signals
  logic                       porDone;
  logic                       porDonePrev;
  logic                       porRelease;
  logic                       mainReady;
  logic                       deglitchExpired;
  logic                       deglitchExpiredPrev;
  logic                       deglitchEnd;
  logic                       s3Prev;
  logic                       s5Prev;
  logic                       inputChange;
  logic                       reqValid;
  acpi_seq_pkg::power_state_t reqState;
  acpi_seq_pkg::power_state_t state;
  logic                       keep3v3Latched;
  logic                       keep5vLatched;
  logic                       mem3v3Latched;
  logic                       railsAllowed;
  logic                       underQualified;
  logic                       faultExpired;

  rail_cmd_if cmd ();

  // ========================================================================
  // Power-on reset extension
  // Counter restarts on every dip, so the supply must stay good throughout
  delay_timer #(
    .CYCLES (POR_CYCLES)
  ) u_por_timer (
    .clk     (clk),
    .rst     (rst),
    .restart (!standbySupplyGood),
    .expired (porDone)
  );

  // Release edge seeds the state and the memory level
  always_ff @(posedge clk) begin
    if (rst) begin
      porDonePrev <= 1'b0;
    end else begin
      porDonePrev <= porDone;
    end
  end

  assign porRelease = porDone && !porDonePrev;

  // ========================================================================
  // Main supply settle timer
  // Held in restart during POR so the settle window is always complete
  delay_timer #(
    .CYCLES (MAIN_READY_CYCLES)
  ) u_main_timer (
    .clk     (clk),
    .rst     (rst),
    .restart (!main12vGood || !porDone),
    .expired (mainReady)
  );

  // ========================================================================
  // Sleep input deglitch
  // Inputs are synchronous, so one sample register is enough
  always_ff @(posedge clk) begin
    if (rst) begin
      s3Prev <= 1'b1;
      s5Prev <= 1'b1;
    end else begin
      s3Prev <= s3RequestN;
      s5Prev <= s5RequestN;
    end
  end

  // S5 edges also restart: absorbs the S3-to-S5 lead on entry to S4/S5
  assign inputChange = (s3RequestN != s3Prev) || (s5RequestN != s5Prev);

  delay_timer #(
    .CYCLES (`ACPI_DEGLITCH_CYC)
  ) u_deglitch_timer (
    .clk     (clk),
    .rst     (rst),
    .restart (inputChange || !porDone),
    .expired (deglitchExpired)
  );

  // One evaluation pulse per settled change
  always_ff @(posedge clk) begin
    if (rst) begin
      deglitchExpiredPrev <= 1'b0;
    end else begin
      deglitchExpiredPrev <= deglitchExpired;
    end
  end

  assign deglitchEnd = deglitchExpired && !deglitchExpiredPrev;

  // ========================================================================
  // Request decode
  // S5 low with S3 high is not a request at all
  always_comb begin
    reqValid = 1'b1;
    reqState = acpi_seq_pkg::ST_ACTIVE;
    unique case ({s5RequestN, s3RequestN})
      2'b11: reqState = acpi_seq_pkg::ST_ACTIVE;
      2'b10: reqState = acpi_seq_pkg::ST_S3;
      2'b00: reqState = acpi_seq_pkg::ST_S45;
      2'b01: reqValid = 1'b0;
    endcase
  end

  // ========================================================================
  // Power state
  // Sleep-to-sleep moves are dropped; after reset release state only changes on deglitch end
  always_ff @(posedge clk) begin
    if (rst || !porDone) begin
      state <= acpi_seq_pkg::ST_S45;
    end else if (porRelease) begin
      state <= reqValid ? reqState : acpi_seq_pkg::ST_S45;
    end else if (deglitchEnd && reqValid) begin
      if ((state == acpi_seq_pkg::ST_ACTIVE) != (reqState == acpi_seq_pkg::ST_ACTIVE)) begin
        state <= reqState;
      end
    end
  end

  // ========================================================================
  // Keep enables and memory level latches
  // Transparent in active, POR and shutdown; frozen while asleep
  always_ff @(posedge clk) begin
    if (rst) begin
      keep3v3Latched <= 1'b1;
      keep5vLatched  <= 1'b0;
    end else if (!porDone || softStartHeldLow || (state == acpi_seq_pkg::ST_ACTIVE)) begin
      keep3v3Latched <= keep_3v3_sleep_enable_n;
      keep5vLatched  <= keep_5v_sleep_enable;
    end
  end

  // Pin is not driven during POR, so the select resistor sets its level
  always_ff @(posedge clk) begin
    if (rst) begin
      mem3v3Latched <= 1'b0;
    end else if (porRelease) begin
      mem3v3Latched <= (fault_and_memsel_pin_in == `ACPI_MEMSEL_3V3);
    end
  end

  // ========================================================================
  // Rail command decode
  assign railsAllowed = porDone && !softStartHeldLow;

  rail_decoder u_decoder (
    .railsAllowed  (railsAllowed),
    .mainReady     (mainReady),
    .state         (state),
    .keep3v3SleepN (keep3v3Latched),
    .keep5vSleep   (keep5vLatched),
    .mem3v3        (mem3v3Latched),
    .cmd           (cmd.source)
  );

  // ========================================================================
  // Output registers
  // Registered so every pin is glitch free against decode hazards
  always_ff @(posedge clk) begin
    if (rst) begin
      active_switch_drive         <= 1'b0;
      standby_5v_switch_drive     <= 1'b0;
      standby_3v3_regulator_drive <= 1'b0;
      memory_active_drive         <= acpi_seq_pkg::MEM_DRIVE_OFF;
      memorySleepPass             <= 1'b0;
      dual3v3RailOn               <= 1'b0;
      dual5vRailOn                <= 1'b0;
      memoryRailOn                <= 1'b0;
    end else begin
      active_switch_drive         <= cmd.activeSwitch;
      standby_5v_switch_drive     <= cmd.standby5v;
      standby_3v3_regulator_drive <= cmd.standby3v3Reg;
      memory_active_drive         <= cmd.memDrive;
      memorySleepPass             <= cmd.memSleepPass;
      dual3v3RailOn               <= cmd.dual3v3On;
      dual5vRailOn                <= cmd.dual5vOn;
      memoryRailOn                <= cmd.memOn;
    end
  end

  // Status mirrors
  always_ff @(posedge clk) begin
    if (rst) begin
      porAsserted     <= 1'b1;
      softStartEnable <= 1'b0;
      memLevel3v3     <= 1'b0;
      powerState      <= acpi_seq_pkg::ST_S45;
    end else begin
      porAsserted     <= !porDone;
      softStartEnable <= railsAllowed;
      memLevel3v3     <= mem3v3Latched;
      powerState      <= state;
    end
  end

  // ========================================================================
  // Under-voltage monitor and fault pin
  // Disabled rails and ramp-up are ignored to avoid false trips
  assign underQualified = softStartRampDone && railsAllowed &&
                          ((cmd.memOn && memoryRailUnder) ||
                           (cmd.dual3v3On && dual3v3RailUnder) ||
                           (cmd.dual5vOn && dual5vRailUnder));

  // Reporting delay filters short dips
  delay_timer #(
    .CYCLES (`ACPI_FAULT_DELAY_CYC)
  ) u_fault_timer (
    .clk     (clk),
    .rst     (rst),
    .restart (!underQualified),
    .expired (faultExpired)
  );

  // Fault only flags; it never feeds back into the rail commands
  always_ff @(posedge clk) begin
    if (rst) begin
      fault_and_memsel_pin_out <= `ACPI_FAULT_FORCED;
      fault_and_memsel_pin_oe  <= 1'b0;
    end else if (porDone && softStartHeldLow) begin
      fault_and_memsel_pin_out <= `ACPI_FAULT_FORCED;
      fault_and_memsel_pin_oe  <= 1'b1;
    end else if (faultExpired) begin
      fault_and_memsel_pin_out <= `ACPI_FAULT_ACTIVE;
      fault_and_memsel_pin_oe  <= 1'b1;
    end else begin
      fault_and_memsel_pin_out <= `ACPI_FAULT_FORCED;
      fault_and_memsel_pin_oe  <= 1'b0;
    end
  end

endmodule

`default_nettype wire

/* File: tb/acpi_sleep_rail_sequencer_properties.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Port-level checks on the rail sequencer
module acpi_sleep_rail_checker (
  // Clock, reset and inputs
  input wire logic clk, rst, s3RequestN, s5RequestN, main12vGood, softStartHeldLow,
  input wire logic memoryRailUnder, dual3v3RailUnder, dual5vRailUnder,
  // Sequencer outputs
  input wire logic fault_and_memsel_pin_out, fault_and_memsel_pin_oe, active_switch_drive,
  input wire logic standby_5v_switch_drive, standby_3v3_regulator_drive, memorySleepPass,
  input wire logic porAsserted, memLevel3v3, dual3v3RailOn, dual5vRailOn, memoryRailOn,
  input wire acpi_seq_pkg::mem_drive_t   memory_active_drive,
  input wire acpi_seq_pkg::power_state_t powerState
);
  logic anyUnder;
  logic drivesOff;
  // Any rail counts here; the bench checks qualification by ramp only, and no check covers qualification by enable
  assign anyUnder = memoryRailUnder | dual3v3RailUnder | dual5vRailUnder;
  assign drivesOff = !active_switch_drive && !standby_5v_switch_drive && !standby_3v3_regulator_drive
                     && !memorySleepPass && memory_active_drive == acpi_seq_pkg::MEM_DRIVE_OFF;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  AST_POR_OFF: assert property (porAsserted && $past(porAsserted) |-> drivesOff)
    else $error("rail drive on during internal reset");
  AST_ILLEGAL_HOLD: assert property ((s3RequestN && !s5RequestN) [*4] |=> $stable(powerState))
    else $error("state moved on illegal request");
  AST_S3_RAILS: assert property (powerState == acpi_seq_pkg::ST_S3
    && $past(powerState) == acpi_seq_pkg::ST_S3 && !softStartHeldLow && !$past(softStartHeldLow) && !porAsserted
    |-> dual3v3RailOn && memoryRailOn && memorySleepPass && !active_switch_drive)
    else $error("suspend rails wrong");
  AST_S45_RAILS: assert property (powerState == acpi_seq_pkg::ST_S45
    && $past(powerState) == acpi_seq_pkg::ST_S45 && !porAsserted |-> !memoryRailOn && !memorySleepPass
    && !active_switch_drive)
    else $error("memory rail on in deep sleep");
  AST_ACTIVE_SW: assert property (active_switch_drive |-> powerState == acpi_seq_pkg::ST_ACTIVE)
    else $error("active switch outside active state");
  AST_STANDBY_5V: assert property (standby_5v_switch_drive |-> powerState != acpi_seq_pkg::ST_ACTIVE && dual5vRailOn)
    else $error("standby switch without sleeping rail");
  AST_MAIN_WAIT: assert property ($rose(main12vGood) |-> !active_switch_drive [*8])
    else $error("active switch too soon after main supply");
  AST_SHUTDOWN: assert property (softStartHeldLow && $past(softStartHeldLow) && !porAsserted
    |-> drivesOff && fault_and_memsel_pin_oe && !fault_and_memsel_pin_out)
    else $error("shutdown not honoured");
  AST_FAULT_DELAY: assert property ($rose(fault_and_memsel_pin_out) |-> $past(anyUnder, 190) && anyUnder)
    else $error("fault without lasting under-voltage");
  AST_DEGLITCH: assert property ($changed(s3RequestN) && !porAsserted |=> $stable(powerState) [*8])
    else $error("state moved inside deglitch time");
  AST_SLEEP_ORDER: assert property (!porAsserted [*4] ##0 powerState != acpi_seq_pkg::ST_ACTIVE
    |=> powerState == acpi_seq_pkg::ST_ACTIVE || $stable(powerState))
    else $error("direct sleep to sleep move");
  AST_MEM_LEVEL: assert property (!porAsserted [*4] |=> $stable(memLevel3v3))
    else $error("memory level changed outside reset trip");
endmodule

bind acpi_sleep_rail_sequencer acpi_sleep_rail_checker i_acpi_sleep_rail_checker (.*);
`default_nettype wire

/* File: tb/chipset_supply_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Chipset sleep outputs and supply comparators
module chipset_supply_model (
  // Clock
  input  wire logic clk,
  // Supply status
  output logic      supplyGood,
  output logic      main12vGood,
  // Sleep requests, low active
  output logic      s3RequestN,
  output logic      s5RequestN
);
  // Standby present, main supply off, system awake
  initial begin
    supplyGood = 1'b1;
    main12vGood = 1'b0;
    s3RequestN = 1'b1;
    s5RequestN = 1'b1;
  end
  // Both lines change on one edge
  task automatic setRequests(input logic s3n, input logic s5n);
    @(posedge clk);
    s3RequestN <= s3n;
    s5RequestN <= s5n;
  endtask
  // S3 falls first or on the same edge as S5, so S5 low never shows with S3 high
  task automatic enterSleep(input logic deep, input int skew);
    setRequests(1'b0, 1'b1);
    if (deep) begin
      repeat (skew) @(posedge clk);
      s5RequestN <= 1'b0;
    end
  endtask
  task automatic supply(input logic v);
    @(posedge clk);
    supplyGood <= v;
  endtask
  task automatic mainPower(input logic v);
    @(posedge clk);
    main12vGood <= v;
  endtask
endmodule
`default_nettype wire

/* File: tb/acpi_sleep_rail_sequencer_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module acpi_sleep_rail_sequencer_bench;
  localparam int POR_CYC = 20;
  localparam int MAIN_CYC = 30;
  localparam int DEGL = 4000;
  // ==========================================================
  // Wiring
  logic clk, rst, supplyGood, main12v, s3N, s5N, keep3v3N, keep5v, ssLow, rampDone, memselHigh;
  logic pinOut, pinOe, pinLevel, actSw, sb5v, sb3v3, sleepPass, porOn, ssEn, mem3v3, on3v3, on5v, onMem;
  logic [2:0] under;
  acpi_seq_pkg::mem_drive_t memDrive;
  acpi_seq_pkg::power_state_t state;
  int num_errors = 0;
  int check_count = 0;
  // Selection resistor level shows only while the pin is released
  assign pinLevel = pinOe ? pinOut : memselHigh;
  acpi_sleep_rail_sequencer #(.POR_CYCLES(POR_CYC), .MAIN_READY_CYCLES(MAIN_CYC)) i_acpi_sleep_rail_sequencer (
    .clk(clk), .rst(rst), .standbySupplyGood(supplyGood), .main12vGood(main12v), .s3RequestN(s3N),
    .s5RequestN(s5N), .keep_3v3_sleep_enable_n(keep3v3N), .keep_5v_sleep_enable(keep5v),
    .softStartHeldLow(ssLow), .softStartRampDone(rampDone), .memoryRailUnder(under[0]),
    .dual3v3RailUnder(under[1]), .dual5vRailUnder(under[2]), .fault_and_memsel_pin_in(pinLevel),
    .fault_and_memsel_pin_out(pinOut), .fault_and_memsel_pin_oe(pinOe), .active_switch_drive(actSw),
    .standby_5v_switch_drive(sb5v), .standby_3v3_regulator_drive(sb3v3), .memory_active_drive(memDrive),
    .memorySleepPass(sleepPass), .porAsserted(porOn), .softStartEnable(ssEn), .memLevel3v3(mem3v3),
    .dual3v3RailOn(on3v3), .dual5vRailOn(on5v), .memoryRailOn(onMem), .powerState(state));
  chipset_supply_model i_chipset_supply_model (.clk(clk), .supplyGood(supplyGood), .main12vGood(main12v),
    .s3RequestN(s3N), .s5RequestN(s5N));
  // ==========================================================
  // Shared checks and waits
  task automatic check(input string what, input logic [3:0] exp, input logic [3:0] got);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %0h seen %0h", what, exp, got);
    end
  endtask
  task automatic inRange(input string what, input int n, input int lo, input int hi);
    check(what, 4'h1, {3'h0, n >= lo && n <= hi});
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // Bounded waits; running out ends the run as a failure
  task automatic waitBit(input string what, ref logic sig, input logic v, input int lim, output int n);
    for (n = 0; sig !== v; n++) begin
      if (n > lim) begin
        check(what, {3'h0, v}, {3'h0, sig});
        end_of_test();
      end
      tick(1);
    end
  endtask
  task automatic waitState(input acpi_seq_pkg::power_state_t s, input int lim, output int n);
    for (n = 0; state !== s; n++) begin
      if (n > lim) begin
        check("state wait", s, state);
        end_of_test();
      end
      tick(1);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // ==========================================================
  // Scenarios
  task automatic t_startup();
    int n;
    waitBit("por", porOn, 1'b0, POR_CYC + 10, n);
    inRange("por delay", n, POR_CYC, POR_CYC + 4);
    tick(3);
    check("ramp and level", 4'h3, {2'h0, ssEn, mem3v3});
    check("state", acpi_seq_pkg::ST_ACTIVE, state);
    check("switch without main", 4'h0, {3'h0, actSw});
    i_chipset_supply_model.mainPower(1'b1);
    waitBit("switch", actSw, 1'b1, MAIN_CYC + 10, n);
    inRange("main delay", n, MAIN_CYC, MAIN_CYC + 4);
    tick(1);
    check("mem drive", acpi_seq_pkg::MEM_DRIVE_FULL, memDrive);
    check("rails", 4'h7, {1'b0, on3v3, on5v, onMem});
    $display("startup done");
  endtask
  task automatic t_suspend();
    int n;
    @(posedge clk) keep3v3N <= 1'b1;
    i_chipset_supply_model.enterSleep(1'b0, 0);
    waitState(acpi_seq_pkg::ST_S3, DEGL + 20, n);
    inRange("deglitch", n, DEGL - 4, DEGL + 4);
    tick(2);
    check("rails", 4'h7, {1'b0, on3v3, on5v, onMem});
    check("drives", 4'h7, {actSw, sb5v, sb3v3, sleepPass});
    @(posedge clk) keep5v <= 1'b0;
    tick(5);
    check("frozen keep", 4'h1, {3'h0, on5v});
    $display("suspend done");
  endtask
  task automatic t_blocked();
    int n;
    i_chipset_supply_model.setRequests(1'b0, 1'b0);
    tick(DEGL + 50);
    check("no s3 to s45", acpi_seq_pkg::ST_S3, state);
    i_chipset_supply_model.setRequests(1'b1, 1'b0);
    tick(DEGL + 50);
    check("illegal hold", acpi_seq_pkg::ST_S3, state);
    check("illegal rails", 4'h7, {1'b0, on3v3, on5v, onMem});
    i_chipset_supply_model.setRequests(1'b1, 1'b1);
    waitState(acpi_seq_pkg::ST_ACTIVE, DEGL + 20, n);
    $display("blocked moves done");
  endtask
  task automatic t_soft_off();
    int n;
    for (int k = 0; k < 2; k++) begin
      @(posedge clk) keep3v3N <= k[0];
      keep5v <= !k[0];
      tick(5);
      i_chipset_supply_model.enterSleep(1'b1, DEGL - 10);
      waitState(acpi_seq_pkg::ST_S45, DEGL + 20, n);
      inRange("skew", n, DEGL - 4, DEGL + 4);
      tick(2);
      check("rails", {1'b0, !k[0], !k[0], 1'b0}, {1'b0, on3v3, on5v, onMem});
      check("drives", {2'h0, !k[0], 1'b0}, {actSw, sleepPass, sb5v, onMem});
      i_chipset_supply_model.setRequests(1'b1, 1'b1);
      waitState(acpi_seq_pkg::ST_ACTIVE, DEGL + 20, n);
    end
    $display("soft off done");
  endtask
  task automatic t_fault();
    int n;
    waitBit("switch", actSw, 1'b1, MAIN_CYC + 10, n);
    @(posedge clk) under <= 3'h1;
    tick(250);
    check("ungated fault", 4'h0, {3'h0, pinOe});
    @(posedge clk) under <= 3'h0;
    rampDone <= 1'b1;
    for (int i = 0; i < 3; i++) begin
      @(posedge clk) under <= 3'h1 << i;
      tick(150);
      check("early fault", 4'h0, {3'h0, pinOut});
      tick(60);
      check("fault", 4'hf, {pinOut, pinOe, actSw, onMem});
      @(posedge clk) under <= 3'h0;
      tick(5);
      check("fault clear", 4'h0, {3'h0, pinOut});
    end
    $display("fault done");
  endtask
  task automatic t_shutdown_and_trip();
    int n;
    @(posedge clk) ssLow <= 1'b1;
    tick(3);
    check("shutdown", 4'h8, {pinOe, pinOut, actSw, sleepPass});
    @(posedge clk) ssLow <= 1'b0;
    memselHigh <= 1'b0;
    i_chipset_supply_model.supply(1'b0);
    tick(4);
    check("trip", 4'h8, {porOn, actSw, sb5v, sleepPass});
    i_chipset_supply_model.supply(1'b1);
    waitBit("por", porOn, 1'b0, POR_CYC + 10, n);
    waitBit("switch", actSw, 1'b1, MAIN_CYC + 20, n);
    tick(1);
    check("level", 4'h0, {3'h0, mem3v3});
    check("mem drive", acpi_seq_pkg::MEM_DRIVE_REGULATE, memDrive);
    $display("shutdown and trip done");
  endtask
  // ==========================================================
  // Clock and main sequence
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial begin
    rst = 1'b1;
    keep3v3N = 1'b0;
    keep5v = 1'b1;
    ssLow = 1'b0;
    rampDone = 1'b0;
    under = 3'h0;
    memselHigh = 1'b1;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    t_startup();
    t_suspend();
    t_blocked();
    t_soft_off();
    t_fault();
    t_shutdown_and_trip();
    end_of_test();
  end
endmodule
`default_nettype wire
